// [pwm_shutdown_top.sv]
// How it works
// - Unit three code 10 takes its PWM time base from Timer 6.
// - Unit two code picks time base: 00 Timer 2, 01 Timer 4, 10 Timer 6.
// - Unit one field in bits 1-0 picks Timer 2, 4 or 6.
// - Status bit 7 sets on shutdown event; outputs held in shutdown state.
// - With status bit clear, PWM outputs follow the unit normally.
// - Bits 6-4 choose which inputs may trigger shutdown.
// - Source code 000 never triggers shutdown.
// - Code 001 triggers while comparator one is high.
// - Code 010 triggers while comparator two is high.
// - Code 011 triggers while either comparator is high.
// - Code 100 triggers while the interrupt pin is low.
// - Code 101 triggers on pin low or comparator one high.
// - Code 110 adds comparator two; 111 pin or either comparator.
// - Pins A and C in shutdown: 00 low, 01 high, 1x tri-state.
// - Pins B and D in shutdown: 00 low, 01 high, 1x tri-state.
// - Comparator sync option delays comparator shutdown to Timer1 stage.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "pwm_shutdown_map.svh"

module pwm_shutdown_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tmr2_tick,
  input wire logic tmr4_tick,
  input wire logic tmr6_tick,
  input wire logic timer1_tick,
  output logic [3:0] unit_tick,
  input wire logic comp1_out,
  input wire logic comp2_out,
  input wire logic int_pin,
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  input wire logic pwm_in_c,
  input wire logic pwm_in_d,
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  output logic pwm_oe_n_a,
  output logic pwm_oe_n_b,
  output logic pwm_oe_n_c,
  output logic pwm_oe_n_d,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic wr_en;
  logic rd_en;
  logic hit;
  logic [7:0] tb_sel_q;
  logic [7:0] tb_sel_d;
  logic [7:0] as_ctrl_q;
  logic [7:0] as_ctrl_d;
  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic trigger;
  logic flag_d;

  function automatic logic is_ofs(input logic [`PADDR_W-1:0] a,
                                  input logic [`PADDR_W-1:0] ofs);
    is_ofs = (a == ofs);
  endfunction

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign hit = is_ofs(paddr, `OFS_TB_SEL) | is_ofs(paddr, `OFS_AS_CTRL)
             | is_ofs(paddr, `OFS_SYNC_CTRL) | is_ofs(paddr, `OFS_IRQ_STAT)
             | is_ofs(paddr, `OFS_IRQ_CLR) | is_ofs(paddr, `OFS_IRQ_EN);
  assign pslverr = psel & penable & ~hit;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and shutdown flag

  always_comb begin
    tb_sel_d = tb_sel_q;
    as_ctrl_d = as_ctrl_q;
    sync_d = sync_q;
    if (wr_en && is_ofs(paddr, `OFS_TB_SEL)) begin
      tb_sel_d = pwdata[7:0];
    end
    if (wr_en && is_ofs(paddr, `OFS_AS_CTRL)) begin
      as_ctrl_d = pwdata[7:0];
    end
    if (wr_en && is_ofs(paddr, `OFS_SYNC_CTRL)) begin
      sync_d = pwdata[1:0];
    end
    // A live trigger wins over a software clear of the flag.
    flag_d = trigger | as_ctrl_d[`FLAG_BIT];
    as_ctrl_d[`FLAG_BIT] = flag_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_sel_q <= `TB_SEL_RST;
      as_ctrl_q <= `AS_CTRL_RST;
      sync_q <= `SYNC_RST;
    end else begin
      tb_sel_q <= tb_sel_d;
      as_ctrl_q <= as_ctrl_d;
      sync_q <= sync_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base selection and shutdown sources

  pwm_timebase_mux u_tb (
    .pclk(pclk),
    .presetn(presetn),
    .tb_sel(tb_sel_q),
    .tmr2_tick(tmr2_tick),
    .tmr4_tick(tmr4_tick),
    .tmr6_tick(tmr6_tick),
    .unit_tick(unit_tick)
  );

  shutdown_source_detect u_src (
    .pclk(pclk),
    .presetn(presetn),
    .comp1_raw(comp1_out),
    .comp2_raw(comp2_out),
    .int_pin_raw(int_pin),
    .timer1_tick(timer1_tick),
    .comparator_sync_enable(sync_q),
    .shutdown_source_sel(as_ctrl_q[`SRC_MSB:`SRC_LSB]),
    .trigger(trigger)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output pins

  logic [3:0] out_d;
  logic [3:0] out_q;
  logic [3:0] oe_n_d;
  logic [3:0] oe_n_q;
  logic [1:0] ac_drv;
  logic [1:0] bd_drv;

  // Returns {output enable low, level} for one shutdown state code.
  function automatic logic [1:0] pin_drive(
      input pwm_shutdown_pkg::pin_state_t code);
    if (code[`PSS_TRI_BIT]) begin
      pin_drive = 2'h2;
    end else begin
      pin_drive = {1'b0, code == `PSS_HIGH};
    end
  endfunction

  // Next field values are used so a state code written together with the
  // flag reaches the pins on that same edge, never the stale code.
  assign ac_drv = pin_drive(as_ctrl_d[`AC_MSB:`AC_LSB]);
  assign bd_drv = pin_drive(as_ctrl_d[`BD_MSB:`BD_LSB]);

  always_comb begin
    // The next flag value is used so the pins change on the same edge
    // the flag sets, with no cycle of live PWM in between.
    if (flag_d) begin
      out_d = {bd_drv[0], ac_drv[0], bd_drv[0], ac_drv[0]};
      oe_n_d = {bd_drv[1], ac_drv[1], bd_drv[1], ac_drv[1]};
    end else begin
      out_d = {pwm_in_d, pwm_in_c, pwm_in_b, pwm_in_a};
      oe_n_d = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 4'h0;
      oe_n_q <= 4'h0;
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pwm_out_a = out_q[0];
  assign pwm_out_b = out_q[1];
  assign pwm_out_c = out_q[2];
  assign pwm_out_d = out_q[3];
  assign pwm_oe_n_a = oe_n_q[0];
  assign pwm_oe_n_b = oe_n_q[1];
  assign pwm_oe_n_c = oe_n_q[2];
  assign pwm_oe_n_d = oe_n_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  pwm_shutdown_pkg::irq_bits_t stat_q;
  pwm_shutdown_pkg::irq_bits_t stat_d;
  pwm_shutdown_pkg::irq_bits_t en_q;
  pwm_shutdown_pkg::irq_bits_t en_d;
  pwm_shutdown_pkg::irq_bits_t ev;

  assign ev[`IRQ_ENTER] = flag_d & ~as_ctrl_q[`FLAG_BIT];
  assign ev[`IRQ_EXIT] = ~flag_d & as_ctrl_q[`FLAG_BIT];

  always_comb begin
    stat_d = stat_q;
    en_d = en_q;
    if (wr_en && is_ofs(paddr, `OFS_IRQ_CLR)) begin
      stat_d = stat_d & ~pwdata[1:0];
    end
    if (wr_en && is_ofs(paddr, `OFS_IRQ_EN)) begin
      en_d = pwdata[1:0];
    end
    // Setting after the clear keeps an event that lands on a clear.
    stat_d = stat_d | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= `IRQ_RST;
      en_q <= `IRQ_RST;
    end else begin
      stat_q <= stat_d;
      en_q <= en_d;
    end
  end

  assign irq = |(stat_q & en_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle

  always_comb begin
    rdata_d = rdata_q;
    if (rd_en) begin
      rdata_d = 32'h0;
      unique case (1'b1)
        is_ofs(paddr, `OFS_TB_SEL): rdata_d[7:0] = tb_sel_q;
        is_ofs(paddr, `OFS_AS_CTRL): rdata_d[7:0] = as_ctrl_q;
        is_ofs(paddr, `OFS_SYNC_CTRL): rdata_d[1:0] = sync_q;
        is_ofs(paddr, `OFS_IRQ_STAT): rdata_d[1:0] = stat_q;
        is_ofs(paddr, `OFS_IRQ_EN): rdata_d[1:0] = en_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_flag_rises;
    !as_ctrl_q[`FLAG_BIT] ##1 as_ctrl_q[`FLAG_BIT];
  endsequence

  chk_unit3_timer6: assert property (
    tb_sel_q[5:4] == `TB_T6 && $stable(tb_sel_q) |=> unit_tick[2] ==
      $past(tmr6_tick))
    else $error("unit three does not follow timer 6");

  chk_unit2_select: assert property (
    tb_sel_q[3:2] == `TB_T4 && $stable(tb_sel_q) |=> unit_tick[1] ==
      $past(tmr4_tick))
    else $error("unit two does not follow timer 4");

  chk_unit1_select: assert property (
    tb_sel_q[1:0] == `TB_T2 && $stable(tb_sel_q) |=> unit_tick[0] ==
      $past(tmr2_tick))
    else $error("unit one does not follow timer 2");

  chk_flag_holds_pins: assert property (
    as_ctrl_q[`FLAG_BIT] && as_ctrl_q[`AC_MSB:`AC_LSB] == `PSS_HIGH
      |-> pwm_out_a && pwm_out_c && !pwm_oe_n_a && !pwm_oe_n_c)
    else $error("pins A and C not held high in shutdown");

  chk_normal_follow: assert property (
    !as_ctrl_q[`FLAG_BIT] |-> pwm_out_b == $past(pwm_in_b)
      && !pwm_oe_n_b)
    else $error("pin B does not follow PWM while running");

  chk_disabled_quiet: assert property (
    as_ctrl_q[`SRC_MSB:`SRC_LSB] == 3'h0 |-> !trigger)
    else $error("shutdown triggered with sources disabled");

  chk_pin_low_trips: assert property (
    as_ctrl_q[`SRC_MSB:`SRC_LSB] == 3'h4 && !int_pin [*3]
      ##1 $stable(as_ctrl_q[`SRC_MSB:`SRC_LSB]) |-> as_ctrl_q[`FLAG_BIT])
    else $error("low interrupt pin did not shut down");

  chk_bd_tristate: assert property (
    as_ctrl_q[`FLAG_BIT] && as_ctrl_q[`BD_MSB] |-> pwm_oe_n_b && pwm_oe_n_d)
    else $error("pins B and D not released in shutdown");

  chk_same_cycle: assert property (
    s_flag_rises |-> oe_n_q == {as_ctrl_q[`BD_MSB], as_ctrl_q[`AC_MSB],
      as_ctrl_q[`BD_MSB], as_ctrl_q[`AC_MSB]})
    else $error("pins not forced in the cycle the flag set");

  chk_set_wins: assert property (
    trigger |=> as_ctrl_q[`FLAG_BIT])
    else $error("live trigger lost by a clear");

endmodule // pwm_shutdown_top

// [pwm_shutdown_map.svh]
`ifndef PWM_SHUTDOWN_MAP_SVH
`define PWM_SHUTDOWN_MAP_SVH

// APB address width and register byte offsets.
`define PADDR_W 8
`define OFS_TB_SEL 8'h00
`define OFS_AS_CTRL 8'h04
`define OFS_SYNC_CTRL 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_CLR 8'h10
`define OFS_IRQ_EN 8'h14

// Reset values.
`define TB_SEL_RST 8'h00
`define AS_CTRL_RST 8'h00
`define SYNC_RST 2'h0
`define IRQ_RST 2'h0

// Auto-shutdown control field positions.
`define FLAG_BIT 7
`define SRC_MSB 6
`define SRC_LSB 4
`define AC_MSB 3
`define AC_LSB 2
`define BD_MSB 1
`define BD_LSB 0

// Source select bit meanings: each set bit adds one source.
`define SRC_C1 0
`define SRC_C2 1
`define SRC_INT 2

// Time base selection codes, two bits per unit.
`define TB_T2 2'h0
`define TB_T4 2'h1
`define TB_T6 2'h2
`define UNITS 4

// Shutdown pin state codes; the upper bit set means tri-state.
`define PSS_LOW 2'h0
`define PSS_HIGH 2'h1
`define PSS_TRI_BIT 1

// Interrupt status bits.
`define IRQ_ENTER 0
`define IRQ_EXIT 1

`endif

// [pwm_shutdown_pkg.sv]
package pwm_shutdown_pkg;
  typedef logic [1:0] tb_sel_t;
  typedef logic [2:0] source_sel_t;
  typedef logic [1:0] pin_state_t;
  typedef logic [1:0] irq_bits_t;
endpackage

// [pwm_timebase_mux.sv]
`timescale 1ns/1ps
`include "pwm_shutdown_map.svh"

module pwm_timebase_mux (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] tb_sel,
  input wire logic tmr2_tick,
  input wire logic tmr4_tick,
  input wire logic tmr6_tick,
  output logic [3:0] unit_tick
);

  logic [3:0] tick_d;
  logic [3:0] tick_q;

  function automatic logic pick(input pwm_shutdown_pkg::tb_sel_t code,
                                input logic t2, input logic t4,
                                input logic t6);
    // The reserved code gives no time base at all.
    unique case (code)
      `TB_T2: pick = t2;
      `TB_T4: pick = t4;
      `TB_T6: pick = t6;
      default: pick = 1'b0;
    endcase
  endfunction

  always_comb begin
    for (int u = 0; u < `UNITS; u++) begin
      tick_d[u] = pick(tb_sel[2*u +: 2], tmr2_tick, tmr4_tick, tmr6_tick);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 4'h0;
    end else begin
      tick_q <= tick_d;
    end
  end

  assign unit_tick = tick_q;

endmodule // pwm_timebase_mux

// [shutdown_source_detect.sv]
`timescale 1ns/1ps
`include "pwm_shutdown_map.svh"

module shutdown_source_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic comp1_raw,
  input wire logic comp2_raw,
  input wire logic int_pin_raw,
  input wire logic timer1_tick,
  input wire logic [1:0] comparator_sync_enable,
  input wire logic [2:0] shutdown_source_sel,
  output logic trigger
);

  // Synchroniser stages: index 0 comp1, 1 comp2, 2 interrupt pin.
  logic [2:0] meta_q;
  logic [2:0] meta_d;
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic [1:0] held_q;
  logic [1:0] held_d;
  logic c1_eff;
  logic c2_eff;

  always_comb begin
    meta_d = {int_pin_raw, comp2_raw, comp1_raw};
    sync_d = meta_q;
    // With the sync option the comparator level only moves on a Timer1
    // tick, which delays a comparator shutdown to that stage.
    held_d = held_q;
    if (timer1_tick) begin
      held_d = sync_q[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 3'h4;
      sync_q <= 3'h4;
      held_q <= 2'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      held_q <= held_d;
    end
  end

  assign c1_eff = comparator_sync_enable[0] ? held_q[0] : sync_q[0];
  assign c2_eff = comparator_sync_enable[1] ? held_q[1] : sync_q[1];

  // Each select bit enables one source, which covers all eight codes.
  assign trigger = (shutdown_source_sel[`SRC_C1] & c1_eff)
                 | (shutdown_source_sel[`SRC_C2] & c2_eff)
                 | (shutdown_source_sel[`SRC_INT] & ~sync_q[2]);

endmodule // shutdown_source_detect

// [comp_pin_model.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Stands in for the two comparators and the external interrupt pin.
// The pin has a pull-up, so it idles high when nothing pulls it low.
// In slow mode a request only shows four clocks later.
module comp_pin_model (
  input wire logic pclk,
  input wire logic [2:0] trip,
  input wire logic slow,
  output logic comp1_out,
  output logic comp2_out,
  output logic int_pin
);
  logic [11:0] hist_q;
  logic [2:0] now_lvl;

  initial begin
    hist_q = 12'h000;
    comp1_out = 1'b0;
    comp2_out = 1'b0;
    int_pin = 1'b1;
  end

  // Levels move off the clock edge, as an analog source would.
  always @(posedge pclk) begin
    hist_q <= {hist_q[8:0], trip};
    #3;
    now_lvl = slow ? hist_q[11:9] : trip;
    comp1_out = now_lvl[0];
    comp2_out = now_lvl[1];
    int_pin = ~now_lvl[2];
  end
endmodule // comp_pin_model

// [tb_top.sv]
`timescale 1ns/1ps
`include "pwm_shutdown_map.svh"

module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] ticks, trip;
  logic t1_tick, slow, c1, c2, ip, hit;
  logic [3:0] pin_in, unit_tick, pout, poe_n, exp4, ac, bd;
  logic [7:0] sels [6] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h27, 8'h9c};
  int n_errors, total_checks;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  comp_pin_model model_u (.pclk(pclk), .trip(trip), .slow(slow),
    .comp1_out(c1), .comp2_out(c2), .int_pin(ip));

  pwm_shutdown_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmr2_tick(ticks[0]), .tmr4_tick(ticks[1]), .tmr6_tick(ticks[2]),
    .timer1_tick(t1_tick), .unit_tick(unit_tick), .comp1_out(c1),
    .comp2_out(c2), .int_pin(ip), .pwm_in_a(pin_in[0]),
    .pwm_in_b(pin_in[1]), .pwm_in_c(pin_in[2]), .pwm_in_d(pin_in[3]),
    .pwm_out_a(pout[0]), .pwm_out_b(pout[1]), .pwm_out_c(pout[2]),
    .pwm_out_d(pout[3]), .pwm_oe_n_a(poe_n[0]), .pwm_oe_n_b(poe_n[1]),
    .pwm_oe_n_c(poe_n[2]), .pwm_oe_n_d(poe_n[3]), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  initial begin
    {presetn, psel, penable, pwrite, t1_tick, slow} = 6'h00;
    {paddr, pwdata, ticks, trip, pin_in} = 50'h0;
    n_errors = 0;
    total_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_AS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({rd, err}, 32'h1);
    // Mixed selections catch a field wired to the wrong unit.
    foreach (sels[i]) begin
      apb(1'b1, `OFS_TB_SEL, {24'h0, sels[i]});
      for (int j = 0; j < 3; j++) begin
        ticks <= 3'b001 << j;
        @(posedge pclk);
        ticks <= 3'h0;
        #1;
        for (int u = 0; u < 4; u++) exp4[u] = sels[i][2*u +: 2] == j;
        chk(unit_tick, exp4);
        @(posedge pclk);
      end
    end
    for (int code = 0; code < 8; code++) begin
      for (int p = 0; p < 4; p++) begin
        apb(1'b1, `OFS_AS_CTRL, {24'h0, 1'b0, code[2:0], 4'h5});
        trip <= (p == 0) ? 3'h0 : 3'b001 << (p - 1);
        settle(6);
        hit = |(code[2:0] & trip);
        chk(pout, {4{hit}});
        apb(1'b0, `OFS_AS_CTRL, 32'h0);
        chk(rd[7:4], {hit, code[2:0]});
        trip <= 3'h0;
        settle(6);
      end
    end
    pin_in <= 4'hf;
    for (int s = 0; s < 4; s++) begin
      ac = s;
      bd = ~ac;
      // Bit 7 written high forces shutdown with every source disabled.
      apb(1'b1, `OFS_AS_CTRL, {24'h0, 4'h8, ac[1:0], bd[1:0]});
      settle(2);
      hit = ~ac[1] & ac[0];
      exp4 = {~bd[1] & bd[0], hit, ~bd[1] & bd[0], hit};
      chk({pout, poe_n}, {exp4, bd[1], ac[1], bd[1], ac[1]});
    end
    apb(1'b1, `OFS_AS_CTRL, 32'h0);
    pin_in <= 4'h5;
    settle(2);
    chk({pout, poe_n}, 8'h50);
    apb(1'b1, `OFS_IRQ_EN, 32'h1);
    apb(1'b1, `OFS_IRQ_CLR, 32'h3);
    settle(1);
    chk(irq, 1'b0);
    slow <= 1'b1;
    apb(1'b1, `OFS_AS_CTRL, 32'h40);
    trip <= 3'h4;
    settle(12);
    chk(irq, 1'b1);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, `OFS_IRQ_EN, 32'h0);
    trip <= 3'h0;
    settle(1);
    chk(irq, 1'b0);
    settle(12);
    apb(1'b1, `OFS_AS_CTRL, 32'h40);
    apb(1'b1, `OFS_IRQ_CLR, 32'h3);
    apb(1'b1, `OFS_IRQ_EN, 32'h1);
    settle(1);
    chk(irq, 1'b0);
    slow <= 1'b0;
    // Without a Timer1 stage pulse the synced comparator must not trip.
    apb(1'b1, `OFS_SYNC_CTRL, 32'h1);
    apb(1'b1, `OFS_AS_CTRL, 32'h10);
    trip <= 3'h1;
    settle(8);
    apb(1'b0, `OFS_AS_CTRL, 32'h0);
    chk(rd[7], 1'b0);
    t1_tick <= 1'b1;
    @(posedge pclk);
    t1_tick <= 1'b0;
    settle(3);
    apb(1'b0, `OFS_AS_CTRL, 32'h0);
    chk(rd[7], 1'b1);
    conclude();
  end
endmodule // tb_top
